// ---- shared/hdcfg_regs.svh ----
// register offsets, field positions and reset values of the hdlc channel configuration block
`ifndef HDCFG_REGS_SVH
`define HDCFG_REGS_SVH
`define HDCFG_ADDR_HDLC_MODE_CH3 8'h8f
`define HDCFG_ADDR_CFG4 8'h90
`define HDCFG_ADDR_CFG5 8'h91
`define HDCFG_ADDR_HDLC_MODE_CH2 8'h92
`define HDCFG_ADDR_CMD 8'h93
`define HDCFG_ADDR_STAT 8'h94
`define HDCFG_ADDR_MASK 8'h95
`define HDCFG_ADDR_TXD1 8'h96
`define HDCFG_ADDR_SEQ1 8'h97
`define HDCFG_ADDR_MODE1 8'h98
`define HDCFG_ADDR_RXLVL3 8'h99
`define HDCFG_RST_BYTE 8'h00
`define HDCFG_HDLC_MODE_CH3_RST 8'h00
`define HDCFG_CMD_RX_MESSAGE_COMPLETE_CH3 0
`define HDCFG_CFG4_THR_LO 0
`define HDCFG_CFG4_THR_HI 1
`define HDCFG_CFG5_EPR 0
`define HDCFG_CFG5_CR 1
`define HDCFG_CFG5_AFX 2
`define HDCFG_MODE_RAC 3
`define HDCFG_MODE_DIV 2
`define HDCFG_MODE_MDS_LSB 5
`define HDCFG_ST_POOL 0
`define HDCFG_ST_FILL 1
`define HDCFG_ST_PPR 2
`define HDCFG_THR_32 6'h20
`define HDCFG_THR_16 6'h10
`define HDCFG_THR_4 6'h04
`define HDCFG_THR_2 6'h02
`define HDCFG_SAPI_BASE 8'h38
`define HDCFG_PPR_PERIOD 24'd10000000
`endif

// ---- shared/hdcfg_pkg.sv ----
// types of the hdlc channel configuration block
package hdcfg_pkg;
    typedef enum logic [2:0] {
        HDCFG_RSV0 = 3'h0, HDCFG_RSV1 = 3'h1, HDCFG_CMP_LO = 3'h2, HDCFG_CMP_HL = 3'h3,
        HDCFG_NO_CMP = 3'h4, HDCFG_CMP_HI = 3'h5, HDCFG_RSV6 = 3'h6, HDCFG_UNFR1 = 3'h7
    } hdcfg_mode_t;
    typedef enum logic [2:0] {
        HDCFG_TX_IDLE = 3'b001,
        HDCFG_TX_DATA = 3'b010,
        HDCFG_TX_FILL = 3'b100
    } hdcfg_tx_t;
endpackage

// ---- design/hdcfg_invert.sv ----
// optional bit inversion of one internal hdlc stream
`timescale 1ns/1ns
module hdcfg_invert (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic inv_i,
    input wire logic bit_i,
    output logic bit_o
);
    // registered stream, inverted when asked
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bit_o <= 1'b0;
        end else begin
            bit_o <= bit_i ^ inv_i;
        end
    end
endmodule

// ---- design/hdcfg_rxbuf.sv ----
// channel 3 receive buffer memory with registered read data
`timescale 1ns/1ns
module hdcfg_rxbuf #(
    parameter int DEPTH = 32
) (
    input wire logic clk_i,
    input wire logic we_i,
    input wire logic [$clog2(DEPTH)-1:0] waddr_i,
    input wire logic [7:0] wdata_i,
    input wire logic [$clog2(DEPTH)-1:0] raddr_i,
    output logic [7:0] rdata_o
);
    logic [7:0] mem_q [DEPTH];
    // write port and registered read port
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem_q[waddr_i] <= wdata_i;
        end
        rdata_o <= mem_q[raddr_i];
    end
endmodule

// ---- design/hdcfg_top.sv ----
// hdlc channel configuration, fill-in transmit and channel 3 receive buffer control
//
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/1ns
`include "hdcfg_regs.svh"
// Functional notes
// - threshold field 00/01/10/11 sizes the readable channel 3 block as 32/16/4/2 bytes.
// - a confirm command after a pool-full event releases the occupied buffer space.
// - with auto fill-in enabled, fill-in units follow an emptied channel 1 transmit buffer.
// - the command/response setting is copied into the report address octet.
// - periodic reporting runs only while its enable bit is one.
// - the channel 2 receiver runs only while its enable bit is one.
// - the channel 3 receiver runs only while its enable bit is one.
// - channel 2 inversion bit inverts every bit of its generated stream.
// - channel 3 inversion bit inverts every bit of its generated stream.
// - channel 3 mode select decodes into compare and unframed modes, others reserved.
module hdcfg_top #(
    parameter int RX_DEPTH = 32,
    parameter logic [23:0] PPR_PERIOD = `HDCFG_PPR_PERIOD
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [0:0] sel_i,
    input wire logic [7:0] dat_i,
    output logic [7:0] dat_o,
    output logic ack_o,
    output logic irq_o,
    input wire logic rx2_bit_i,
    input wire logic rx3_bit_i,
    input wire logic rx3_valid_i,
    input wire logic [7:0] rx3_byte_i,
    input wire logic tx2_bit_i,
    input wire logic tx3_bit_i,
    input wire logic tx1_ready_i,
    output logic [7:0] tx1_byte_o,
    output logic tx1_valid_o,
    output logic tx1_fill_o,
    output logic ppr_valid_o,
    output logic [7:0] ppr_sapi_o,
    output logic rx2_on_o,
    output logic rx3_on_o,
    output logic rx2_bit_o,
    output logic rx3_bit_o,
    output logic tx2_bit_o,
    output logic tx3_bit_o,
    output logic [3:0] hdlc_mode_ch3_dec_o
);
    import hdcfg_pkg::*;
    localparam int AW = $clog2(RX_DEPTH);

    logic [7:0] hdlc_mode_ch3_q, cfg4_q, cfg5_q, hdlc_mode_ch2_q, mode1_q, mask_q, stat_q;
    logic [7:0] txd1_q, seq1_q, last_seq_q;
    logic txd1_full_q;
    hdcfg_tx_t tx_q;
    logic [AW:0] rx_cnt_q, blk_q;
    logic [AW-1:0] wptr_q, rptr_q;
    logic [23:0] ppr_cnt_q;
    logic [7:0] rx_rdata;
    logic [5:0] thr_bytes;
    logic acc, wr, rd, rx_message_complete_ch3, pool_ev, fill_ev, ppr_ev, rx_push;
    logic [7:0] rd_d;

    assign acc = cyc_i & stb_i & ~ack_o;
    assign wr = acc & we_i & sel_i[0];
    assign rd = acc & ~we_i;
    assign rx_message_complete_ch3 = wr && adr_i == `HDCFG_ADDR_CMD && dat_i[`HDCFG_CMD_RX_MESSAGE_COMPLETE_CH3];

    // threshold decode
    always_comb begin
        case (cfg4_q[`HDCFG_CFG4_THR_HI:`HDCFG_CFG4_THR_LO])
            2'b00: thr_bytes = `HDCFG_THR_32;
            2'b01: thr_bytes = `HDCFG_THR_16;
            2'b10: thr_bytes = `HDCFG_THR_4;
            default: thr_bytes = `HDCFG_THR_2;
        endcase
    end

    // bus ack, one wait cycle, dropped after one cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= acc;
        end
    end

    // configuration registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hdlc_mode_ch3_q <= `HDCFG_HDLC_MODE_CH3_RST;
            cfg4_q <= `HDCFG_RST_BYTE;
            cfg5_q <= `HDCFG_RST_BYTE;
            hdlc_mode_ch2_q <= `HDCFG_RST_BYTE;
            mode1_q <= `HDCFG_RST_BYTE;
            mask_q <= `HDCFG_RST_BYTE;
        end else if (wr) begin
            if (adr_i == `HDCFG_ADDR_HDLC_MODE_CH3) begin
                hdlc_mode_ch3_q <= dat_i;
            end else if (adr_i == `HDCFG_ADDR_CFG4) begin
                cfg4_q <= dat_i;
            end else if (adr_i == `HDCFG_ADDR_CFG5) begin
                cfg5_q <= dat_i;
            end else if (adr_i == `HDCFG_ADDR_HDLC_MODE_CH2) begin
                hdlc_mode_ch2_q <= dat_i;
            end else if (adr_i == `HDCFG_ADDR_MODE1) begin
                mode1_q <= dat_i;
            end else if (adr_i == `HDCFG_ADDR_MASK) begin
                mask_q <= dat_i;
            end
        end
    end

    // read mux, unmapped addresses read zero
    always_comb begin
        rd_d = 8'h00;
        if (adr_i == `HDCFG_ADDR_HDLC_MODE_CH3) begin
            rd_d = hdlc_mode_ch3_q;
        end else if (adr_i == `HDCFG_ADDR_CFG4) begin
            rd_d = cfg4_q;
        end else if (adr_i == `HDCFG_ADDR_CFG5) begin
            rd_d = cfg5_q;
        end else if (adr_i == `HDCFG_ADDR_HDLC_MODE_CH2) begin
            rd_d = hdlc_mode_ch2_q;
        end else if (adr_i == `HDCFG_ADDR_MODE1) begin
            rd_d = mode1_q;
        end else if (adr_i == `HDCFG_ADDR_MASK) begin
            rd_d = mask_q;
        end else if (adr_i == `HDCFG_ADDR_STAT) begin
            rd_d = stat_q;
        end else if (adr_i == `HDCFG_ADDR_SEQ1) begin
            rd_d = seq1_q;
        end else if (adr_i == `HDCFG_ADDR_RXLVL3) begin
            rd_d = rx_rdata;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 8'h00;
        end else if (rd) begin
            dat_o <= rd_d;
        end
    end

    // sticky status, a read clears it but a new event wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stat_q <= 8'h00;
        end else begin
            stat_q <= (rd && adr_i == `HDCFG_ADDR_STAT) ? 8'h00 : stat_q;
            if (pool_ev) stat_q[`HDCFG_ST_POOL] <= 1'b1;
            if (fill_ev) stat_q[`HDCFG_ST_FILL] <= 1'b1;
            if (ppr_ev) stat_q[`HDCFG_ST_PPR] <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(stat_q & mask_q);
        end
    end

    // channel 3 receive buffer: accept while on, block by threshold
    assign rx_push = rx3_valid_i & hdlc_mode_ch3_q[`HDCFG_MODE_RAC] & (rx_cnt_q < RX_DEPTH[AW:0]);
    assign pool_ev = rx_push && (rx_cnt_q - blk_q + 1'b1) == thr_bytes[AW:0];
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wptr_q <= '0;
            rptr_q <= '0;
            rx_cnt_q <= '0;
            blk_q <= '0;
        end else begin
            if (rx_push) wptr_q <= wptr_q + 1'b1;
            if (rd && adr_i == `HDCFG_ADDR_RXLVL3 && blk_q != 0) rptr_q <= rptr_q + 1'b1;
            if (pool_ev) blk_q <= thr_bytes[AW:0];
            if (rx_message_complete_ch3) begin
                rx_cnt_q <= rx_cnt_q - blk_q + {{AW{1'b0}}, rx_push};
                blk_q <= '0;
            end else if (rx_push) begin
                rx_cnt_q <= rx_cnt_q + 1'b1;
            end
        end
    end

    hdcfg_rxbuf #(.DEPTH(RX_DEPTH)) u_rxbuf (
        .clk_i(clk_i),
        .we_i(rx_push),
        .waddr_i(wptr_q),
        .wdata_i(rx3_byte_i),
        .raddr_i(rptr_q),
        .rdata_o(rx_rdata)
    );

    // channel 1 transmit holding byte, written by software
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            txd1_q <= 8'h00;
            txd1_full_q <= 1'b0;
        end else if (wr && adr_i == `HDCFG_ADDR_TXD1) begin
            txd1_q <= dat_i;
            txd1_full_q <= 1'b1;
        end else if (tx_q == HDCFG_TX_DATA && tx1_ready_i) begin
            txd1_full_q <= 1'b0;
        end
    end

    // sequence number pair of the signal unit, remembered for fill-ins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            seq1_q <= 8'h00;
            last_seq_q <= 8'h00;
        end else if (wr && adr_i == `HDCFG_ADDR_SEQ1) begin
            seq1_q <= dat_i;
        end else if (tx_q == HDCFG_TX_DATA && tx1_ready_i) begin
            last_seq_q <= seq1_q;
        end
    end

    // channel 1 transmit sequencer
    assign fill_ev = tx_q == HDCFG_TX_DATA && tx1_ready_i && cfg5_q[`HDCFG_CFG5_AFX];
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_q <= HDCFG_TX_IDLE;
            tx1_valid_o <= 1'b0;
            tx1_fill_o <= 1'b0;
            tx1_byte_o <= 8'h00;
        end else begin
            case (tx_q)
                HDCFG_TX_IDLE: begin
                    if (txd1_full_q) begin
                        tx_q <= HDCFG_TX_DATA;
                        tx1_valid_o <= 1'b1;
                        tx1_fill_o <= 1'b0;
                        tx1_byte_o <= txd1_q;
                    end
                end
                HDCFG_TX_DATA: begin
                    if (tx1_ready_i) begin
                        if (cfg5_q[`HDCFG_CFG5_AFX]) begin
                            tx_q <= HDCFG_TX_FILL;
                            tx1_fill_o <= 1'b1;
                            tx1_byte_o <= seq1_q;
                        end else begin
                            tx_q <= HDCFG_TX_IDLE;
                            tx1_valid_o <= 1'b0;
                        end
                    end
                end
                HDCFG_TX_FILL: begin
                    if (txd1_full_q) begin
                        tx_q <= HDCFG_TX_DATA;
                        tx1_fill_o <= 1'b0;
                        tx1_byte_o <= txd1_q;
                    end else if (!cfg5_q[`HDCFG_CFG5_AFX]) begin
                        tx_q <= HDCFG_TX_IDLE;
                        tx1_valid_o <= 1'b0;
                        tx1_fill_o <= 1'b0;
                    end else begin
                        tx1_byte_o <= last_seq_q;
                    end
                end
                default: tx_q <= HDCFG_TX_IDLE;
            endcase
        end
    end

    // periodic performance report timer
    assign ppr_ev = cfg5_q[`HDCFG_CFG5_EPR] && ppr_cnt_q == PPR_PERIOD - 24'd1;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ppr_cnt_q <= 24'd0;
            ppr_valid_o <= 1'b0;
            ppr_sapi_o <= 8'h00;
        end else begin
            ppr_valid_o <= ppr_ev;
            if (!cfg5_q[`HDCFG_CFG5_EPR] || ppr_ev) begin
                ppr_cnt_q <= 24'd0;
            end else begin
                ppr_cnt_q <= ppr_cnt_q + 24'd1;
            end
            if (ppr_ev) begin
                ppr_sapi_o <= `HDCFG_SAPI_BASE | {6'h00, cfg5_q[`HDCFG_CFG5_CR], 1'b0};
            end
        end
    end

    // receiver enables, stream gating and mode decode
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx2_on_o <= 1'b0;
            rx3_on_o <= 1'b0;
            rx2_bit_o <= 1'b0;
            rx3_bit_o <= 1'b0;
            hdlc_mode_ch3_dec_o <= 4'h0;
        end else begin
            rx2_on_o <= hdlc_mode_ch2_q[`HDCFG_MODE_RAC];
            rx3_on_o <= hdlc_mode_ch3_q[`HDCFG_MODE_RAC];
            rx2_bit_o <= rx2_bit_i & hdlc_mode_ch2_q[`HDCFG_MODE_RAC];
            rx3_bit_o <= rx3_bit_i & hdlc_mode_ch3_q[`HDCFG_MODE_RAC];
            case (hdcfg_mode_t'(hdlc_mode_ch3_q[`HDCFG_MODE_MDS_LSB+:3]))
                HDCFG_CMP_LO: hdlc_mode_ch3_dec_o <= 4'h1;
                HDCFG_CMP_HL: hdlc_mode_ch3_dec_o <= 4'h2;
                HDCFG_NO_CMP: hdlc_mode_ch3_dec_o <= 4'h3;
                HDCFG_CMP_HI: hdlc_mode_ch3_dec_o <= 4'h4;
                HDCFG_UNFR1: hdlc_mode_ch3_dec_o <= 4'h5;
                default: hdlc_mode_ch3_dec_o <= 4'h0;
            endcase
        end
    end

    // generated stream inversion per channel
    hdcfg_invert u_inv2 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .inv_i(hdlc_mode_ch2_q[`HDCFG_MODE_DIV]),
        .bit_i(tx2_bit_i),
        .bit_o(tx2_bit_o)
    );
    hdcfg_invert u_inv3 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .inv_i(hdlc_mode_ch3_q[`HDCFG_MODE_DIV]),
        .bit_i(tx3_bit_i),
        .bit_o(tx3_bit_o)
    );
endmodule

// ---- sim/hdcfg_assertions.sv ----
// concurrent checks on the ports of the hdlc channel configuration block
`timescale 1ns/1ns
module hdcfg_assertions (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic ack_o,
    input wire logic rx2_on_o,
    input wire logic rx3_on_o,
    input wire logic rx2_bit_o,
    input wire logic rx3_bit_o,
    input wire logic tx2_bit_i,
    input wire logic tx3_bit_i,
    input wire logic tx2_bit_o,
    input wire logic tx3_bit_o,
    input wire logic ppr_valid_o,
    input wire logic [7:0] ppr_sapi_o,
    input wire logic tx1_valid_o,
    input wire logic tx1_fill_o,
    input wire logic [7:0] tx1_byte_o,
    input wire logic [3:0] hdlc_mode_ch3_dec_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // request answered after one edge, answer lasts a single cycle
    sequence s_req; cyc_i && stb_i && !ack_o; endsequence
    property p_ack; s_req |=> ack_o ##1 !ack_o; endproperty
    a_ack: assert property (p_ack) else $error("bus answer timing wrong");
    // a receiver held off passes no bits
    sequence s_off2; !rx2_on_o ##1 !rx2_on_o; endsequence
    sequence s_off3; !rx3_on_o ##1 !rx3_on_o; endsequence
    property p_rx2_off; s_off2 |-> !rx2_bit_o; endproperty
    a_rx2_off: assert property (p_rx2_off) else $error("rx2 bit passed while off");
    property p_rx3_off; s_off3 |-> !rx3_bit_o; endproperty
    a_rx3_off: assert property (p_rx3_off) else $error("rx3 bit passed while off");
    // with the inversion setting steady every input change shows one edge later
    property p_inv2;
        $changed(tx2_bit_i) && !ack_o && !$past(rst_i) |=> $changed(tx2_bit_o);
    endproperty
    a_inv2: assert property (p_inv2) else $error("tx2 stream lost a bit change");
    property p_inv3;
        $changed(tx3_bit_i) && !ack_o && !$past(rst_i) |=> $changed(tx3_bit_o);
    endproperty
    a_inv3: assert property (p_inv3) else $error("tx3 stream lost a bit change");
    // report octet carries the fixed base with only the command/response bit free
    property p_sapi; ppr_valid_o |-> (ppr_sapi_o & 8'hfd) == 8'h38; endproperty
    a_sapi: assert property (p_sapi) else $error("report octet wrong");
    property p_ppr; $rose(ppr_valid_o) |=> !ppr_valid_o [*8]; endproperty
    a_ppr: assert property (p_ppr) else $error("report pulses too close");
    // decode stays in its code set and moves only after a register access
    property p_hdlc_mode_ch3;
        hdlc_mode_ch3_dec_o <= 4'h5 && ($stable(hdlc_mode_ch3_dec_o) || ack_o || $past(ack_o) || $past(rst_i));
    endproperty
    a_hdlc_mode_ch3: assert property (p_hdlc_mode_ch3) else $error("mode decode wrong");
    // repeated fill-in units keep the same sequence byte
    sequence s_fill2; tx1_fill_o ##1 tx1_fill_o; endsequence
    property p_fill; s_fill2 |-> tx1_valid_o && $stable(tx1_byte_o); endproperty
    a_fill: assert property (p_fill) else $error("fill-in unit changed");
endmodule

// ---- sim/hdcfg_slot_sink.sv ----
// signaling time slot sink taking channel 1 units at full or throttled pace
`timescale 1ns/1ns
module hdcfg_slot_sink (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic slow_i,
    input wire logic valid_i,
    input wire logic fill_i,
    input wire logic [7:0] byte_i,
    output logic ready_o,
    output logic [7:0] data_o,
    output logic [7:0] fillb_o,
    output logic [7:0] cnt_o
);
    logic [1:0] ph_q;
    // phase counter, throttled sink is ready one cycle in three
    always_ff @(posedge clk_i) begin
        ph_q <= (rst_i || ph_q == 2'h2) ? 2'h0 : ph_q + 2'h1;
    end
    assign ready_o = !rst_i && (!slow_i || ph_q == 2'h2);
    // keep last data byte and last fill-in byte apart, count all units
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            data_o <= 8'h00;
            fillb_o <= 8'h00;
            cnt_o <= 8'h00;
        end else if (valid_i && ready_o) begin
            cnt_o <= cnt_o + 8'h01;
            if (fill_i) begin
                fillb_o <= byte_i;
            end else begin
                data_o <= byte_i;
            end
        end
    end
endmodule

// ---- sim/tb_top.sv ----
// self-checking bench of the hdlc channel configuration block
`timescale 1ns/1ns
`include "hdcfg_regs.svh"
module tb_top;
    logic clk_i, rst_i, cyc_i, stb_i, we_i, rx3_valid_i, slow, e;
    logic rx2_bit_i, rx3_bit_i, tx2_bit_i, tx3_bit_i;
    logic [0:0] sel_i;
    logic [7:0] adr_i, dat_i, rx3_byte_i, r, m0;
    logic [3:0] dec[8] = '{4'h0, 4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h0, 4'h5};
    int thr[4] = '{32, 16, 4, 2};
    wire logic [7:0] dat_o, tx1_byte_o, ppr_sapi_o, s_data, s_fill, s_cnt;
    wire logic ack_o, irq_o, tx1_ready_i, tx1_valid_o, tx1_fill_o, ppr_valid_o;
    wire logic rx2_on_o, rx3_on_o, rx2_bit_o, rx3_bit_o, tx2_bit_o, tx3_bit_o;
    wire logic [3:0] hdlc_mode_ch3_dec_o;
    int fail_count, checked, n;

    hdcfg_top #(.PPR_PERIOD(24'h000014)) dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
        .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .irq_o, .rx2_bit_i, .rx3_bit_i,
        .rx3_valid_i, .rx3_byte_i, .tx2_bit_i, .tx3_bit_i, .tx1_ready_i, .tx1_byte_o,
        .tx1_valid_o, .tx1_fill_o, .ppr_valid_o, .ppr_sapi_o, .rx2_on_o, .rx3_on_o,
        .rx2_bit_o, .rx3_bit_o, .tx2_bit_o, .tx3_bit_o, .hdlc_mode_ch3_dec_o);
    hdcfg_slot_sink u_sink (.clk_i, .rst_i, .slow_i(slow), .valid_i(tx1_valid_o),
        .fill_i(tx1_fill_o), .byte_i(tx1_byte_o), .ready_o(tx1_ready_i), .data_o(s_data),
        .fillb_o(s_fill), .cnt_o(s_cnt));

    // 10 mhz clock
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    task automatic complete_run();
        if (fail_count == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // classic single bus cycle, read data left in r
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int k;
        k = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        do begin
            @(posedge clk_i);
            k++;
        end while (ack_o !== 1'b1 && k < 20);
        if (k == 20) fail_count++;
        r = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        wb(1'b0, a, 8'h00);
        chk(r, x);
    endtask

    task automatic push(input logic [7:0] b);
        rx3_valid_i <= 1'b1;
        rx3_byte_i <= b;
        @(posedge clk_i);
        rx3_valid_i <= 1'b0;
        @(posedge clk_i);
    endtask

    // wait for k more units taken by the sink
    task automatic waitn(input int k);
        m0 = s_cnt;
        n = 0;
        while (8'(s_cnt - m0) < k && n < 300) begin
            @(posedge clk_i);
            n++;
        end
        if (n == 300) fail_count++;
    endtask

    // wait for a report pulse, n reaches 100 when none came
    task automatic pw();
        n = 0;
        while (ppr_valid_o !== 1'b1 && n < 100) begin
            @(posedge clk_i);
            n++;
        end
    endtask

    // main sequence
    initial begin
        {rst_i, slow} = 2'b11;
        {cyc_i, stb_i, we_i, rx3_valid_i, rx2_bit_i, rx3_bit_i, tx2_bit_i, tx3_bit_i} = 8'h00;
        {adr_i, dat_i, rx3_byte_i} = 24'h000000;
        sel_i = 1'b1;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(`HDCFG_ADDR_HDLC_MODE_CH2, `HDCFG_RST_BYTE);
        rd(`HDCFG_ADDR_HDLC_MODE_CH3, `HDCFG_HDLC_MODE_CH3_RST);
        rd(`HDCFG_ADDR_CFG4, `HDCFG_RST_BYTE);
        rd(8'h50, 8'h00);
        for (int m = 0; m < 8; m++) begin
            wb(1'b1, `HDCFG_ADDR_HDLC_MODE_CH3, 8'(m << 5));
            rd(`HDCFG_ADDR_HDLC_MODE_CH3, 8'(m << 5));
            chk(8'(hdlc_mode_ch3_dec_o), 8'(dec[m]));
        end
        for (int v = 0; v < 2; v++) begin
            e = (v == 0);
            wb(1'b1, `HDCFG_ADDR_HDLC_MODE_CH2, e ? 8'h0c : 8'h00);
            wb(1'b1, `HDCFG_ADDR_HDLC_MODE_CH3, e ? 8'h0c : 8'h00);
            for (int b = 0; b < 2; b++) begin
                {rx2_bit_i, rx3_bit_i, tx2_bit_i, tx3_bit_i} <= {b[0], !b[0], b[0], !b[0]};
                repeat (2) @(posedge clk_i);
                chk(8'({rx2_on_o, rx3_on_o, rx2_bit_o, rx3_bit_o, tx2_bit_o, tx3_bit_o}),
                    8'({e, e, b[0] & e, !b[0] & e, b[0] ^ e, !b[0] ^ e}));
            end
        end
        wb(1'b1, `HDCFG_ADDR_HDLC_MODE_CH3, 8'h08);
        wb(1'b0, `HDCFG_ADDR_STAT, 8'h00);
        for (int t = 0; t < 4; t++) begin
            wb(1'b1, `HDCFG_ADDR_CFG4, 8'(t));
            wb(1'b1, `HDCFG_ADDR_MASK, t == 3 ? 8'h00 : 8'h01);
            for (int i = 1; i < thr[t]; i++) push(8'(i));
            chk(8'(irq_o), 8'h00);
            push(8'hee);
            @(posedge clk_i);
            chk(8'(irq_o), t == 3 ? 8'h00 : 8'h01);
            rd(`HDCFG_ADDR_STAT, 8'h01);
            rd(`HDCFG_ADDR_STAT, 8'h00);
            chk(8'(irq_o), 8'h00);
            for (int i = 0; i < thr[t]; i++) begin
                rd(`HDCFG_ADDR_RXLVL3, i == thr[t] - 1 ? 8'hee : 8'(i + 1));
            end
            wb(1'b1, `HDCFG_ADDR_CMD, 8'h01);
        end
        wb(1'b1, `HDCFG_ADDR_SEQ1, 8'h5a);
        wb(1'b1, `HDCFG_ADDR_CFG5, 8'h04);
        wb(1'b1, `HDCFG_ADDR_TXD1, 8'ha5);
        waitn(4);
        chk(s_data, 8'ha5);
        chk(s_fill, 8'h5a);
        rd(`HDCFG_ADDR_STAT, 8'h02);
        slow <= 1'b0;
        wb(1'b1, `HDCFG_ADDR_TXD1, 8'h33);
        waitn(4);
        chk(s_data, 8'h33);
        chk(s_fill, 8'h5a);
        wb(1'b1, `HDCFG_ADDR_MODE1, 8'h40);
        wb(1'b1, `HDCFG_ADDR_CFG5, 8'h03);
        pw();
        chk(ppr_sapi_o, 8'h3a);
        wb(1'b1, `HDCFG_ADDR_CFG5, 8'h01);
        pw();
        chk(ppr_sapi_o, 8'h38);
        wb(1'b1, `HDCFG_ADDR_CFG5, 8'h00);
        pw();
        chk(8'(n), 8'h64);
        complete_run();
    end

    // watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge clk_i);
        fail_count++;
        complete_run();
    end
endmodule

bind hdcfg_top hdcfg_assertions u_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .ack_o, .rx2_on_o,
    .rx3_on_o, .rx2_bit_o, .rx3_bit_o, .tx2_bit_i, .tx3_bit_i, .tx2_bit_o, .tx3_bit_o,
    .ppr_valid_o, .ppr_sapi_o, .tx1_valid_o, .tx1_fill_o, .tx1_byte_o, .hdlc_mode_ch3_dec_o);
